// ### include/lsr_regs.vh
// register map, field layout, reset values and decode constants of the limiter settings block
`ifndef LSR_REGS_VH
`define LSR_REGS_VH

// two-wire bus
`define LSR_DEV_ADDR        7'h48
`define LSR_BYTE_BITS       4'h8
`define LSR_LAST_TX_BIT     4'h7

// register offsets
`define LSR_OFS_SLICE       8'h01
`define LSR_OFS_EMPH        8'h02
`define LSR_OFS_SWING       8'h03
`define LSR_OFS_SLOT_A      8'h04
`define LSR_OFS_SLOT_B      8'h05
`define LSR_OFS_SLOT_C      8'h06
`define LSR_OFS_SLOT_D      8'h07
`define LSR_OFS_READBACK    8'h0e

// writable bit masks, unassigned positions stay zero
`define LSR_MASK_SLICE      8'hff
`define LSR_MASK_EMPH       8'h0f
`define LSR_MASK_SWING      8'h03
`define LSR_MASK_SLOT       8'h8f

// reset values
`define LSR_RST_SLICE       8'h80
`define LSR_RST_EMPH        8'h00
`define LSR_RST_SWING       8'h00
`define LSR_RST_SLOT        8'h00

// field positions
`define LSR_SLOT_USE_BIT    7
`define LSR_SLOT_CODE_RANGE 3:0
`define LSR_SLICE_MID       8'h80

// emphasis codes in order of 0..8 db
`define LSR_EMPH_0DB        4'h0
`define LSR_EMPH_1DB        4'h1
`define LSR_EMPH_2DB        4'h3
`define LSR_EMPH_3DB        4'h4
`define LSR_EMPH_4DB        4'h5
`define LSR_EMPH_5DB        4'h7
`define LSR_EMPH_6DB        4'hc
`define LSR_EMPH_7DB        4'hd
`define LSR_EMPH_8DB        4'hf

// swing codes and levels in mvpp
`define LSR_SWING_LOW       2'h0
`define LSR_SWING_MID_A     2'h1
`define LSR_SWING_MID_B     2'h2
`define LSR_SWING_HIGH      2'h3
`define LSR_SWING_MV_LOW    10'd350
`define LSR_SWING_MV_MID    10'd650
`define LSR_SWING_MV_HIGH   10'd850

// default filter bandwidths in mhz
`define LSR_BW_DEF_A        14'd2400
`define LSR_BW_DEF_B        14'd7600
`define LSR_BW_DEF_C        14'd8400
`define LSR_BW_DEF_D        14'd9000

`endif

// ### src/lsr_bw_select.v
// picks the bandwidth slot from the speed pins and resolves its code or default
`timescale 1ns/1ps
`include "lsr_regs.vh"

module lsr_bw_select (
  input  wire        speed_hi,
  input  wire        speed_lo,
  input  wire [7:0]  slot_a,
  input  wire [7:0]  slot_b,
  input  wire [7:0]  slot_c,
  input  wire [7:0]  slot_d,
  output reg  [3:0]  bw_code,
  output reg         bw_use_default,
  output reg  [13:0] bw_default_mhz
);

  reg [7:0] slot;

  // slot choice by pin pair, then code or fixed default
  always @* begin
    slot           = slot_d;
    bw_default_mhz = `LSR_BW_DEF_D;                 // RULE_11
    case ({speed_hi, speed_lo})
      2'b00: begin
        slot           = slot_a;                    // RULE_06
        bw_default_mhz = `LSR_BW_DEF_A;             // RULE_05
      end
      2'b01: begin
        slot           = slot_b;                    // RULE_09
        bw_default_mhz = `LSR_BW_DEF_B;             // RULE_08
      end
      2'b11: begin
        slot           = slot_c;                    // RULE_10
        bw_default_mhz = `LSR_BW_DEF_C;
      end
      default: begin
        slot           = slot_d;                    // RULE_11
        bw_default_mhz = `LSR_BW_DEF_D;
      end
    endcase
    bw_use_default = ~slot[`LSR_SLOT_USE_BIT];      // RULE_05
    bw_code        = slot[`LSR_SLOT_CODE_RANGE];    // RULE_04
  end

endmodule // lsr_bw_select

// ### src/lsr_settings.v
// two-wire slave with the limiter setting registers and their decoded outputs
//
// Notes on behaviour
// (RULE_01) slice code 128 is zero shift, below is positive, above grows negative to 255.
// (RULE_02) emphasis codes 0,1,3,4,5,7,c,d,f give 0 to 8 db.
// (RULE_03) swing 00 is 350 mvpp, 01 and 10 are 650, 11 is 850.
// (RULE_04) slot a use bit set: bandwidth from slot a low nibble.
// (RULE_05) slot a use bit clear: low bits ignored, default 2.4 ghz.
// (RULE_06) slot a applies when both speed pins are low.
// (RULE_07) slot b use bit set: bandwidth from slot b low nibble.
// (RULE_08) slot b use bit clear: low bits ignored, default 7.6 ghz.
// (RULE_09) slot b applies when high pin is 0 and low pin is 1.
// (RULE_10) slot c, default 8.4 ghz, applies when both pins are 1.
// (RULE_11) slot d, default 9.0 ghz, applies for high 1 low 0 or open pins.
// (RULE_12) applied 4-bit bandwidth reads back at address 0x0e.
// (RULE_13) unassigned bits read zero and ignore writes.
`timescale 1ns/1ps
`include "lsr_regs.vh"

module lsr_settings #(
  parameter [6:0] DEV_ADDR = `LSR_DEV_ADDR
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  input  wire        speed_pin_hi,
  input  wire        speed_pin_lo,
  output reg  [7:0]  slice_shift_code,
  output reg         slice_shift_pos,
  output reg         slice_shift_neg,
  output reg  [7:0]  slice_shift_mag,
  output reg  [3:0]  emphasis_db,
  output reg         emphasis_code_bad,
  output reg  [9:0]  output_swing_mv,
  output reg  [3:0]  applied_bw_code,
  output reg         applied_bw_default,
  output reg  [13:0] applied_bw_default_mhz
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_RX   = 3'd3;
  localparam [2:0] ST_TX   = 3'd4;
  localparam [2:0] ST_RACK = 3'd5;

  // pin synchronisers, the third stage only serves edge detection
  reg  [2:0]  scl_sync;
  reg  [2:0]  sda_sync;
  reg  [1:0]  speed_hi_sync;
  reg  [1:0]  speed_lo_sync;

  reg  [2:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  ptr;
  reg         have_ptr;
  reg         rw;
  reg         master_ack;

  reg  [7:0]  slice_shift;
  reg  [7:0]  emphasis_level;
  reg  [7:0]  output_swing;
  reg  [7:0]  bandwidth_slot_a;
  reg  [7:0]  bandwidth_slot_b;
  reg  [7:0]  bandwidth_slot_c;
  reg  [7:0]  bandwidth_slot_d;

  wire [3:0]  sel_code;
  wire        sel_default;
  wire [13:0] sel_default_mhz;
  wire [7:0]  rd_data;

  wire scl_s    = scl_sync[1];
  wire scl_d    = scl_sync[2];
  wire sda_s    = sda_sync[1];
  wire sda_d    = sda_sync[2];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  // register read mux, unassigned positions come back zero
  function [7:0] read_reg;
    input [7:0] addr;
    begin
      case (addr)
        `LSR_OFS_SLICE:    read_reg = slice_shift & `LSR_MASK_SLICE;          // RULE_13
        `LSR_OFS_EMPH:     read_reg = emphasis_level & `LSR_MASK_EMPH;        // RULE_13
        `LSR_OFS_SWING:    read_reg = output_swing & `LSR_MASK_SWING;         // RULE_13
        `LSR_OFS_SLOT_A:   read_reg = bandwidth_slot_a & `LSR_MASK_SLOT;
        `LSR_OFS_SLOT_B:   read_reg = bandwidth_slot_b & `LSR_MASK_SLOT;
        `LSR_OFS_SLOT_C:   read_reg = bandwidth_slot_c & `LSR_MASK_SLOT;
        `LSR_OFS_SLOT_D:   read_reg = bandwidth_slot_d & `LSR_MASK_SLOT;
        `LSR_OFS_READBACK: read_reg = {4'h0, applied_bw_code};                // RULE_12
        default:           read_reg = 8'h00;
      endcase
    end
  endfunction

  // emphasis code to db, unlisted codes give 0 db and a flag
  function [4:0] emph_decode;
    input [3:0] code;
    begin
      case (code)
        `LSR_EMPH_0DB: emph_decode = {1'b0, 4'd0};
        `LSR_EMPH_1DB: emph_decode = {1'b0, 4'd1};
        `LSR_EMPH_2DB: emph_decode = {1'b0, 4'd2};
        `LSR_EMPH_3DB: emph_decode = {1'b0, 4'd3};
        `LSR_EMPH_4DB: emph_decode = {1'b0, 4'd4};
        `LSR_EMPH_5DB: emph_decode = {1'b0, 4'd5};
        `LSR_EMPH_6DB: emph_decode = {1'b0, 4'd6};
        `LSR_EMPH_7DB: emph_decode = {1'b0, 4'd7};
        `LSR_EMPH_8DB: emph_decode = {1'b0, 4'd8};
        default:       emph_decode = {1'b1, 4'd0};
      endcase
    end
  endfunction

  assign rd_data = read_reg(ptr);

  // slot selection from the synchronised speed pins
  lsr_bw_select u_bw_select (
    .speed_hi       (speed_hi_sync[1]),
    .speed_lo       (speed_lo_sync[1]),
    .slot_a         (bandwidth_slot_a),
    .slot_b         (bandwidth_slot_b),
    .slot_c         (bandwidth_slot_c),
    .slot_d         (bandwidth_slot_d),
    .bw_code        (sel_code),
    .bw_use_default (sel_default),
    .bw_default_mhz (sel_default_mhz)
  );

  // two-stage synchronisers plus edge stage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync      <= 3'b111;
      sda_sync      <= 3'b111;
      speed_hi_sync <= 2'b00;
      speed_lo_sync <= 2'b00;
    end else begin
      scl_sync      <= {scl_sync[1:0], scl_in};
      sda_sync      <= {sda_sync[1:0], sda_in};
      speed_hi_sync <= {speed_hi_sync[0], speed_pin_hi};
      speed_lo_sync <= {speed_lo_sync[0], speed_pin_lo};
    end
  end

  // two-wire slave: address, pointer, write data with auto increment, read data
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= ST_IDLE;
      bit_cnt          <= 4'h0;
      shreg            <= 8'h00;
      ptr              <= 8'h00;
      have_ptr         <= 1'b0;
      rw               <= 1'b0;
      master_ack       <= 1'b0;
      sda_oe           <= 1'b0;
      slice_shift      <= `LSR_RST_SLICE;
      emphasis_level   <= `LSR_RST_EMPH;
      output_swing     <= `LSR_RST_SWING;
      bandwidth_slot_a <= `LSR_RST_SLOT;
      bandwidth_slot_b <= `LSR_RST_SLOT;
      bandwidth_slot_c <= `LSR_RST_SLOT;
      bandwidth_slot_d <= `LSR_RST_SLOT;
    end else if (bus_start) begin
      state    <= ST_ADDR;
      bit_cnt  <= 4'h0;
      have_ptr <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (bus_stop) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `LSR_BYTE_BITS) begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin
                rw     <= shreg[0];
                sda_oe <= 1'b1;
                state  <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              state  <= ST_ACK;
              if (!have_ptr) begin
                ptr      <= shreg;
                have_ptr <= 1'b1;
              end else begin
                ptr <= ptr + 8'h01;
                case (ptr)
                  `LSR_OFS_SLICE:  slice_shift      <= shreg & `LSR_MASK_SLICE;   // RULE_13
                  `LSR_OFS_EMPH:   emphasis_level   <= shreg & `LSR_MASK_EMPH;    // RULE_13
                  `LSR_OFS_SWING:  output_swing     <= shreg & `LSR_MASK_SWING;   // RULE_13
                  `LSR_OFS_SLOT_A: bandwidth_slot_a <= shreg & `LSR_MASK_SLOT;    // RULE_13
                  `LSR_OFS_SLOT_B: bandwidth_slot_b <= shreg & `LSR_MASK_SLOT;
                  `LSR_OFS_SLOT_C: bandwidth_slot_c <= shreg & `LSR_MASK_SLOT;
                  `LSR_OFS_SLOT_D: bandwidth_slot_d <= shreg & `LSR_MASK_SLOT;
                  default: ;
                endcase
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw) begin
              shreg  <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              ptr    <= ptr + 8'h01;
              state  <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == `LSR_LAST_TX_BIT) begin
              sda_oe <= 1'b0;
              state  <= ST_RACK;
            end else begin
              sda_oe  <= ~shreg[7];
              shreg   <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (master_ack) begin
              shreg  <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              ptr    <= ptr + 8'h01;
              state  <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // decoded settings toward the analog blocks
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slice_shift_code       <= `LSR_RST_SLICE;
      slice_shift_pos        <= 1'b0;
      slice_shift_neg        <= 1'b0;
      slice_shift_mag        <= 8'h00;
      emphasis_db            <= 4'h0;
      emphasis_code_bad      <= 1'b0;
      output_swing_mv        <= `LSR_SWING_MV_LOW;
      applied_bw_code        <= 4'h0;
      applied_bw_default     <= 1'b1;
      applied_bw_default_mhz <= `LSR_BW_DEF_A;
    end else begin
      slice_shift_code <= slice_shift;
      slice_shift_pos  <= slice_shift < `LSR_SLICE_MID;                        // RULE_01
      slice_shift_neg  <= slice_shift > `LSR_SLICE_MID;                        // RULE_01
      slice_shift_mag  <= (slice_shift < `LSR_SLICE_MID) ? (`LSR_SLICE_MID - slice_shift)
                                                         : (slice_shift - `LSR_SLICE_MID); // RULE_01
      {emphasis_code_bad, emphasis_db} <= emph_decode(emphasis_level[3:0]);   // RULE_02
      case (output_swing[1:0])                                                 // RULE_03
        `LSR_SWING_LOW:   output_swing_mv <= `LSR_SWING_MV_LOW;
        `LSR_SWING_MID_A: output_swing_mv <= `LSR_SWING_MV_MID;
        `LSR_SWING_MID_B: output_swing_mv <= `LSR_SWING_MV_MID;
        default:          output_swing_mv <= `LSR_SWING_MV_HIGH;
      endcase
      applied_bw_code        <= sel_code;                                      // RULE_07
      applied_bw_default     <= sel_default;                                   // RULE_04
      applied_bw_default_mhz <= sel_default_mhz;
    end
  end

endmodule // lsr_settings

// ### tb/lsr_checker.sv
// concurrent checks on the ports of the limiter settings block
`timescale 1ns/1ps
`include "lsr_regs.vh"
module lsr_checker (
  input wire        clk,
  input wire        reset_n,
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        speed_pin_hi,
  input wire        speed_pin_lo,
  input wire [7:0]  slice_shift_code,
  input wire        slice_shift_pos,
  input wire        slice_shift_neg,
  input wire [7:0]  slice_shift_mag,
  input wire [3:0]  emphasis_db,
  input wire        emphasis_code_bad,
  input wire [9:0]  output_swing_mv,
  input wire [13:0] applied_bw_default_mhz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // slice code settled for a cycle, so its decode has caught up
  sequence code_held;
    $stable(slice_shift_code);
  endsequence
  // speed pins steady past the sync flops and the output stage
  sequence pins_held;
    $stable({speed_pin_hi, speed_pin_lo}) [*4];
  endsequence
  a_sda_only_low: assert property (sda_out == 1'b0) else $error("sda drive value not low");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved while scl high");
  a_slice_pos: assert property (code_held |=> slice_shift_pos == (slice_shift_code < 8'h80))
    else $error("slice positive flag wrong");
  a_slice_neg: assert property (code_held |=> slice_shift_neg == (slice_shift_code > 8'h80))
    else $error("slice negative flag wrong");
  a_slice_mag: assert property (code_held |=> slice_shift_mag == ((slice_shift_code < 8'h80) ?
    8'h80 - slice_shift_code : slice_shift_code - 8'h80)) else $error("slice magnitude wrong");
  a_emph_bad_zero: assert property (emphasis_code_bad |-> emphasis_db == 4'h0)
    else $error("bad emphasis code not zero db");
  a_emph_range: assert property (emphasis_db <= 4'h8) else $error("emphasis above 8 db");
  a_swing_set: assert property (output_swing_mv inside {`LSR_SWING_MV_LOW, `LSR_SWING_MV_MID,
    `LSR_SWING_MV_HIGH}) else $error("swing level off the table");
  a_pin_slot: assert property (pins_held |-> applied_bw_default_mhz == (speed_pin_hi ?
    (speed_pin_lo ? `LSR_BW_DEF_C : `LSR_BW_DEF_D) : (speed_pin_lo ? `LSR_BW_DEF_B : `LSR_BW_DEF_A)))
    else $error("slot default does not follow speed pins");
endmodule // lsr_checker
bind lsr_settings lsr_checker u_chk (.clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .speed_pin_hi(speed_pin_hi), .speed_pin_lo(speed_pin_lo), .slice_shift_code(slice_shift_code),
  .slice_shift_pos(slice_shift_pos), .slice_shift_neg(slice_shift_neg), .slice_shift_mag(slice_shift_mag),
  .emphasis_db(emphasis_db), .emphasis_code_bad(emphasis_code_bad), .output_swing_mv(output_swing_mv),
  .applied_bw_default_mhz(applied_bw_default_mhz));

// ### tb/lsr_host.sv
// two-wire host model that drives the setting registers
`timescale 1ns/1ps
module lsr_host (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  integer i;
  reg     r;
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bus phase, longer than the device's sync delay
  task ph;
    repeat (4) @(negedge clk);
  endtask
  // start or repeated start
  task start;
    begin
      sda_low = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda_low = 1'b1;
      ph;
      scl = 1'b0;
    end
  endtask
  // stop from scl low
  task stop;
    begin
      ph;
      sda_low = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda_low = 1'b0;
      ph;
    end
  endtask
  // data moves only while scl is low, sampled at the end of high
  task bit_io(input b, output q);
    begin
      ph;
      sda_low = ~b;
      ph;
      scl = 1'b1;
      ph;
      q = sda;
      scl = 1'b0;
    end
  endtask
  // msb first byte, ninth bit released so the device may answer
  task xfer(input [7:0] d, output [7:0] q, output ack);
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], q[i]);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
endmodule // lsr_host

// ### tb/lsr_settings_tb_top.sv
// self-checking bench with a register model for the limiter settings
`timescale 1ns/1ps
`include "lsr_regs.vh"
module lsr_settings_tb_top;
  localparam [63:0] EDB = 64'h8f76_ffff_5f43_2f10;
  reg         clk, reset_n, speed_hi, speed_lo, ack;
  wire        scl, host_low, sda_out, sda_oe, sda, slice_pos, slice_neg, emph_bad, bw_def;
  wire [7:0]  slice_code, slice_mag;
  wire [3:0]  emph_db, bw_code;
  wire [9:0]  swing_mv;
  wire [13:0] bw_mhz;
  integer     bad_count, checks, seed, k, s;
  integer     mdl [0:15];
  reg  [7:0]  q, v;
  // open-drain data wire with pull-up
  assign sda = ~(host_low | (sda_oe & ~sda_out));
  lsr_settings uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .speed_pin_hi(speed_hi), .speed_pin_lo(speed_lo), .slice_shift_code(slice_code),
    .slice_shift_pos(slice_pos), .slice_shift_neg(slice_neg), .slice_shift_mag(slice_mag),
    .emphasis_db(emph_db), .emphasis_code_bad(emph_bad), .output_swing_mv(swing_mv),
    .applied_bw_code(bw_code), .applied_bw_default(bw_def), .applied_bw_default_mhz(bw_mhz));
  lsr_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // writable bits of each register
  function integer msk(input integer p);
    msk = p == 1 ? 255 : p == 2 ? 15 : p == 3 ? 3 : (p >= 4 && p <= 7) ? 143 : 0;
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // write n bytes from pointer p, later bytes random below the top bit of d
  // local random word, so the caller's slot index in s survives the write
  task wr(input [7:0] p, input integer n, input [7:0] d);
    integer j, t;
    begin
      host.start;
      host.xfer({`LSR_DEV_ADDR, 1'b0}, q, ack);
      host.xfer(p, q, ack);
      for (j = 0; j < n; j = j + 1) begin
        t = $random(seed);
        v = j ? {d[7], t[6:0]} : d;
        host.xfer(v, q, ack);
        chk("write ack", 1, ack);
        mdl[p + j] = v & msk(p + j);
      end
      host.stop;
    end
  endtask
  task rd(input [7:0] p, input integer e);
    begin
      host.start;
      host.xfer({`LSR_DEV_ADDR, 1'b0}, q, ack);
      host.xfer(p, q, ack);
      host.start;
      host.xfer({`LSR_DEV_ADDR, 1'b1}, q, ack);
      chk("read ack", 1, ack);
      host.xfer(8'hff, q, ack);
      host.stop;
      chk("read data", e, q);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // watchdog against a hung bus
  initial begin
    #3200000;
    bad_count = bad_count + 1;
    end_sim;
  end
  // main sequence
  initial begin
    bad_count = 0;
    checks = 0;
    seed = 32'h4c4d5f58;
    reset_n = 1'b0;
    speed_hi = 1'b0;
    speed_lo = 1'b0;
    for (k = 0; k < 16; k = k + 1)
      mdl[k] = 0;
    mdl[1] = 128;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("slice code", 16'h0080, slice_code);
    chk("swing", 350, swing_mv);
    chk("bw default", 1, bw_def);
    for (k = 1; k < 6; k = k + 1)
      rd(k, mdl[k]);
    $display("test reset done");
    for (k = 0; k < 7; k = k + 1) begin
      s = $random(seed);
      v = k == 0 ? 0 : k == 1 ? 127 : k == 2 ? 128 : k == 3 ? 129 : k == 4 ? 255 : s[7:0];
      wr(1, 1, v);
      s = v;
      chk("slice code", v, slice_code);
      chk("slice pos", s < 128, slice_pos);
      chk("slice neg", s > 128, slice_neg);
      chk("slice mag", s < 128 ? 128 - s : s - 128, slice_mag);
    end
    $display("test slice done");
    for (k = 0; k < 16; k = k + 1) begin
      v = $random(seed);
      wr(2, 1, {v[7:4], k[3:0]});
      s = EDB[k * 4 +: 4];
      chk("emph db", s == 15 ? 0 : s, emph_db);
      chk("emph bad", s == 15, emph_bad);
      rd(2, mdl[2]);
    end
    $display("test emphasis done");
    for (k = 0; k < 4; k = k + 1) begin
      v = $random(seed);
      wr(3, 1, {v[7:2], k[1:0]});
      chk("swing", k == 0 ? 350 : k == 3 ? 850 : 650, swing_mv);
      rd(3, mdl[3]);
    end
    $display("test swing done");
    for (k = 0; k < 8; k = k + 1) begin
      v = $random(seed);
      wr(4, 4, {k[2], v[6:0]});
      speed_hi = k[1];
      speed_lo = k[0];
      repeat (6) @(negedge clk);
      s = k[1] ? (k[0] ? 6 : 7) : (k[0] ? 5 : 4);
      chk("bw code", mdl[s] & 15, bw_code);
      chk("bw default", mdl[s] < 128, bw_def);
      chk("bw mhz", s == 4 ? `LSR_BW_DEF_A : s == 5 ? `LSR_BW_DEF_B :
          s == 6 ? `LSR_BW_DEF_C : `LSR_BW_DEF_D, bw_mhz);
      rd(8'h0e, mdl[s] & 15);
    end
    $display("test slots done");
    wr(8'h0e, 1, 8'hff);
    rd(8'h0e, mdl[s] & 15);
    wr(8'h00, 1, 8'hff);
    rd(8'h00, 0);
    host.start;
    host.xfer({`LSR_DEV_ADDR ^ 7'h01, 1'b0}, q, ack);
    host.stop;
    chk("foreign addr ack", 0, ack);
    $display("test refused done");
    end_sim;
  end
endmodule // lsr_settings_tb_top
